// ---- verilog/fieldbus_supervisor_map.vh ----
// Constants for the fieldbus slave status supervisor
`ifndef FIELDBUS_SUPERVISOR_MAP_VH
`define FIELDBUS_SUPERVISOR_MAP_VH

// Clock and timing
`define CLK_HZ 10000000
`define CFG_TIMEOUT_S 30
// 30 s at 10 MHz, sized to the timer so nothing is cut silently
`define CFG_TIMEOUT_CYCLES 29'h11e1a300
`define CFG_TIMER_W 29
`define BLINK_SLOW_HZ 1
`define BLINK_MID_HZ 2
`define BLINK_FAST_HZ 4
// Half periods of the 1, 2 and 4 Hz flash codes at 10 MHz
`define BLINK_SLOW_HALF 23'h4c4b40
`define BLINK_MID_HALF 23'h2625a0
`define BLINK_FAST_HALF 23'h1312d0
`define BLINK_W 23
`define SAMPLE_WAIT 2'h3

// Station address
`define DIGIT_MAX 4'h9
`define TENS_WEIGHT 7'h0a
`define ADDR_W 7

// Image layout
`define IMAGE_W 128
`define GCC_CLR_W 24
`define BASE_LED_W 5

// Register map
`define REG_ADDR_W 4
`define REG_STATION 4'h0
`define REG_IRQ_STATUS 4'h4
`define REG_IRQ_MASK 4'h8
`define REG_INDICATOR 4'hc

// Event bits of status and mask
`define EV_W 4
`define EV_TIMEOUT 0
`define EV_JOIN 1
`define EV_GCC 2
`define EV_FAULT 3
`define EV_RESET 4'h0

// Fault code (indicator register bits 6:4)
`define FC_NONE 3'h0
`define FC_LEN 3'h1
`define FC_CFG 3'h2
`define FC_INIT 3'h3
`define FC_WDOG 3'h4

`endif

// ---- verilog/sync_2ff.v ----
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // sync_2ff
`default_nettype wire

// ---- verilog/blink_divider.v ----
// Free-running square wave for indicator flash codes
`timescale 1ns/100ps
`default_nettype none
`include "fieldbus_supervisor_map.vh"
module blink_divider #(
  parameter [`BLINK_W-1:0] HALF_CYCLES = `BLINK_SLOW_HALF
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Square wave, high first half period after reset
  output wire wave_out
);
  reg [`BLINK_W-1:0] count_reg;
  reg wave_reg;

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count_reg <= {`BLINK_W{1'b0}};
      wave_reg <= 1'b1;
    end else if (count_reg == HALF_CYCLES - 1'b1) begin
      count_reg <= {`BLINK_W{1'b0}};
      wave_reg <= ~wave_reg;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign wave_out = wave_reg;
endmodule // blink_divider
`default_nettype wire

// ---- verilog/fieldbus_slave_status_supervisor.v ----
// Start-up, address, clear and indicator supervisor of a fieldbus slave module
// Function
// - The station address is accepted only when it lies in decimal 0 to 99 from two decimal selectors.
// - The upper selector gives the tens digit, combined with the lower selector as ones.
// - The lower selector gives the ones digit, so settings three and six give address 36.
// - After power-up or reset the block configures itself and starts with no operator action.
// - Without a configuration from the base unit within 30 s the block still joins the bus online.
// - On joining after that timeout an external-error diagnostic is sent to the master.
// - The online indicator is steady while online with data exchange possible, off otherwise.
// - On Global Control Clear the online indicator flashes and virtual inputs 0 to 23 go to zero.
// - While Global Control Clear is active, virtual inputs 24 to 127 keep their last values.
// - The offline indicator is steady while offline with no data exchange, off otherwise.
// - The fault indicator flashes at 1 Hz on an input or output length mismatch at start-up.
// - The fault indicator flashes at 2 Hz on a configuration length or contents mismatch.
// - It flashes at 4 Hz on bus start-up failure, is steady on watchdog timeout, else off.
// - Output byte 3 carries the five base unit indicators in bits 0-4 and data exchange in bit 5.
// - Virtual inputs map eight to a byte, input number being eight times byte plus bit.
`timescale 1ns/100ps
`default_nettype none
`include "fieldbus_supervisor_map.vh"
module fieldbus_slave_status_supervisor #(
  parameter [`CFG_TIMER_W-1:0] CFG_TIMEOUT_CYCLES = `CFG_TIMEOUT_CYCLES,
  parameter [`BLINK_W-1:0] SLOW_HALF_CYCLES = `BLINK_SLOW_HALF,
  parameter [`BLINK_W-1:0] MID_HALF_CYCLES = `BLINK_MID_HALF,
  parameter [`BLINK_W-1:0] FAST_HALF_CYCLES = `BLINK_FAST_HALF
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Rotary selector pins
  input wire [3:0] tens_digit_selector_in,
  input wire [3:0] ones_digit_selector_in,
  // Base unit side
  input wire cfg_received_in,
  input wire [`BASE_LED_W-1:0] base_led_status_in,
  // Protocol engine status
  input wire dp_online_in,
  input wire gcc_active_in,
  input wire len_mismatch_in,
  input wire cfg_mismatch_in,
  input wire dp_init_fail_in,
  input wire wdog_timeout_in,
  // Input image from the master
  input wire [`IMAGE_W-1:0] master_image_in,
  input wire master_image_valid_in,
  // Register port
  input wire [`REG_ADDR_W-1:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [31:0] reg_rdata_out,
  // Station address and bus control
  output wire [`ADDR_W-1:0] station_address_out,
  output wire address_valid_out,
  output wire bus_join_out,
  output wire ext_diagnostic_indicator_req_out,
  // Images
  output wire [`IMAGE_W-1:0] virtual_inputs_out,
  output wire [7:0] status_byte_out,
  // Indicators and interrupt
  output wire online_led_out,
  output wire offline_led_out,
  output wire fault_led_out,
  output wire irq_out
);
  localparam [1:0] ST_SAMPLE = 2'h0;
  localparam [1:0] ST_WAIT_CFG = 2'h1;
  localparam [1:0] ST_JOINED = 2'h2;
  localparam [1:0] ST_BAD_ADDR = 2'h3;

  wire [3:0] tens_sync;
  wire [3:0] ones_sync;
  wire blink_slow;
  wire blink_mid;
  wire blink_fast;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] wait_reg;
  reg [`CFG_TIMER_W-1:0] timer_reg;
  reg [`ADDR_W-1:0] addr_reg;
  reg addr_ok_reg;
  reg join_reg;
  reg ext_diagnostic_indicator_reg;
  reg [`IMAGE_W-1:0] image_reg;
  reg [7:0] status_byte_reg;
  reg online_led_reg;
  reg offline_led_reg;
  reg fault_led_reg;
  reg [2:0] fault_code;
  reg fault_wave;
  reg [`EV_W-1:0] irq_status_reg;
  reg [`EV_W-1:0] irq_mask_reg;
  reg [`EV_W-1:0] ev_set;
  reg irq_reg;
  reg [31:0] rdata_reg;
  reg gcc_prev_reg;
  reg fault_prev_reg;

  // A selector left on a hex position blocks joining rather than guessing an address
  wire digits_ok = (tens_sync <= `DIGIT_MAX) && (ones_sync <= `DIGIT_MAX);
  wire online_now = join_reg && dp_online_in;
  // Timer runs only while waiting, so the limit counts from address capture
  wire timed_out = (state_reg == ST_WAIT_CFG) && (timer_reg == CFG_TIMEOUT_CYCLES - 1'b1);
  wire join_now = (state_reg == ST_WAIT_CFG) && (cfg_received_in || timed_out);
  wire fault_any = wdog_timeout_in | dp_init_fail_in | cfg_mismatch_in | len_mismatch_in;

  sync_2ff #(
    .WIDTH(8)
  ) u_selector_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({tens_digit_selector_in, ones_digit_selector_in}),
    .sync_out({tens_sync, ones_sync})
  );

  blink_divider #(
    .HALF_CYCLES(SLOW_HALF_CYCLES)
  ) u_blink_slow (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .wave_out(blink_slow)
  );

  blink_divider #(
    .HALF_CYCLES(MID_HALF_CYCLES)
  ) u_blink_mid (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .wave_out(blink_mid)
  );

  blink_divider #(
    .HALF_CYCLES(FAST_HALF_CYCLES)
  ) u_blink_fast (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .wave_out(blink_fast)
  );

  // Start-up sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_SAMPLE: begin
        // Wait for the synchroniser to carry real selector levels
        if (wait_reg == `SAMPLE_WAIT) begin
          state_next = digits_ok ? ST_WAIT_CFG : ST_BAD_ADDR;
        end
      end
      ST_WAIT_CFG: begin
        if (join_now) begin
          state_next = ST_JOINED;
        end
      end
      ST_JOINED: state_next = ST_JOINED;
      ST_BAD_ADDR: state_next = ST_BAD_ADDR;
      default: state_next = ST_SAMPLE;
    endcase
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_SAMPLE;
      wait_reg <= 2'h0;
      timer_reg <= {`CFG_TIMER_W{1'b0}};
      addr_reg <= {`ADDR_W{1'b0}};
      addr_ok_reg <= 1'b0;
      join_reg <= 1'b0;
      ext_diagnostic_indicator_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ext_diagnostic_indicator_reg <= 1'b0;
      if (state_reg == ST_SAMPLE) begin
        wait_reg <= wait_reg + 1'b1;
        if (wait_reg == `SAMPLE_WAIT) begin
          // Captured once; later selector turns are ignored until reset
          addr_reg <= {3'h0, tens_sync} * `TENS_WEIGHT + {3'h0, ones_sync};
          addr_ok_reg <= digits_ok;
        end
      end
      if (state_reg == ST_WAIT_CFG) begin
        timer_reg <= timer_reg + 1'b1;
      end
      if (join_now) begin
        join_reg <= 1'b1;
        ext_diagnostic_indicator_reg <= timed_out && !cfg_received_in;
      end
    end
  end

  // Virtual input image
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      image_reg <= {`IMAGE_W{1'b0}};
    end else if (gcc_active_in) begin
      // Low bits cleared, extended bits frozen while the clear lasts
      image_reg[`GCC_CLR_W-1:0] <= {`GCC_CLR_W{1'b0}};
    end else if (master_image_valid_in && join_reg) begin
      image_reg <= master_image_in;
    end
  end

  // Priority fault code and flash selection
  always @* begin
    if (wdog_timeout_in) begin
      fault_code = `FC_WDOG;
      fault_wave = 1'b1;
    end else if (dp_init_fail_in) begin
      fault_code = `FC_INIT;
      fault_wave = blink_fast;
    end else if (cfg_mismatch_in) begin
      fault_code = `FC_CFG;
      fault_wave = blink_mid;
    end else if (len_mismatch_in) begin
      fault_code = `FC_LEN;
      fault_wave = blink_slow;
    end else begin
      fault_code = `FC_NONE;
      fault_wave = 1'b0;
    end
  end

  // Indicators and status byte
  // Flash phase runs free, so a new clear may start in mid-period
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      online_led_reg <= 1'b0;
      offline_led_reg <= 1'b0;
      fault_led_reg <= 1'b0;
      status_byte_reg <= 8'h00;
    end else begin
      if (online_now && gcc_active_in) begin
        online_led_reg <= blink_mid;
      end else begin
        online_led_reg <= online_now;
      end
      offline_led_reg <= !online_now;
      fault_led_reg <= fault_wave;
      status_byte_reg <= {2'h0, online_now, base_led_status_in};
    end
  end

  // Interrupt events
  // Edge events fire once per rise; a level held high does not re-arm them
  always @* begin
    ev_set = `EV_RESET;
    ev_set[`EV_TIMEOUT] = join_now && timed_out && !cfg_received_in;
    ev_set[`EV_JOIN] = join_now;
    ev_set[`EV_GCC] = gcc_active_in && !gcc_prev_reg;
    ev_set[`EV_FAULT] = fault_any && !fault_prev_reg;
  end

  // Register port and sticky status; an event beats a same-cycle clear
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= `EV_RESET;
      irq_mask_reg <= `EV_RESET;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      gcc_prev_reg <= 1'b0;
      fault_prev_reg <= 1'b0;
    end else begin
      gcc_prev_reg <= gcc_active_in;
      fault_prev_reg <= fault_any;
      if (reg_wr_in && reg_addr_in == `REG_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~reg_wdata_in[`EV_W-1:0]) | ev_set;
      end else begin
        irq_status_reg <= irq_status_reg | ev_set;
      end
      if (reg_wr_in && reg_addr_in == `REG_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata_in[`EV_W-1:0];
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
      rdata_reg <= 32'h0000_0000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `REG_STATION: rdata_reg <= {20'h00000, state_reg, 1'b0, addr_ok_reg, 1'b0, addr_reg};
          `REG_IRQ_STATUS: rdata_reg <= {28'h0000000, irq_status_reg};
          `REG_IRQ_MASK: rdata_reg <= {28'h0000000, irq_mask_reg};
          `REG_INDICATOR: rdata_reg <= {25'h0000000, fault_code, fault_led_reg,
                                        offline_led_reg, online_led_reg, join_reg};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign station_address_out = addr_reg;
  assign address_valid_out = addr_ok_reg;
  assign bus_join_out = join_reg;
  assign ext_diagnostic_indicator_req_out = ext_diagnostic_indicator_reg;
  assign virtual_inputs_out = image_reg;
  assign status_byte_out = status_byte_reg;
  assign online_led_out = online_led_reg;
  assign offline_led_out = offline_led_reg;
  assign fault_led_out = fault_led_reg;
  assign irq_out = irq_reg;
endmodule // fieldbus_slave_status_supervisor
`default_nettype wire

// ---- tb/fieldbus_slave_status_supervisor_asserts.sv ----
// Concurrent checks on the supervisor top-level ports
`timescale 1ns/100ps
`default_nettype none
module supervisor_checker (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Inputs watched
  input wire logic cfg_received_in,
  input wire logic dp_online_in,
  input wire logic gcc_active_in,
  input wire logic wdog_timeout_in,
  // Outputs watched
  input wire logic bus_join_out,
  input wire logic ext_diagnostic_indicator_req_out,
  input wire logic [127:0] virtual_inputs_out,
  input wire logic online_led_out,
  input wire logic offline_led_out,
  input wire logic fault_led_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_join_cause: assert property (
    $rose(bus_join_out) |-> $past(cfg_received_in) || ext_diagnostic_indicator_req_out)
    else $error("join without cause");
  chk_diagnostic_indicator_join: assert property (
    ext_diagnostic_indicator_req_out |-> $rose(bus_join_out) ##1 !ext_diagnostic_indicator_req_out)
    else $error("diagnostic outside join");
  chk_join_hold: assert property (bus_join_out |=> bus_join_out)
    else $error("join dropped");
  chk_gcc_clear: assert property (
    gcc_active_in |=> virtual_inputs_out[23:0] == 24'h0)
    else $error("low inputs not cleared");
  chk_gcc_freeze: assert property (
    gcc_active_in |=> $stable(virtual_inputs_out[127:24]))
    else $error("high inputs not frozen");
  chk_online_led: assert property (
    bus_join_out && dp_online_in && !gcc_active_in |=> online_led_out)
    else $error("online lamp dark");
  chk_offline_led: assert property (
    rst_n_in && !(bus_join_out && dp_online_in) |=> offline_led_out && !online_led_out)
    else $error("offline lamp wrong");
  chk_wdog_steady: assert property (wdog_timeout_in |=> fault_led_out)
    else $error("fault lamp dark");
  cov_timeout_join: cover property (ext_diagnostic_indicator_req_out);
  cov_cfg_join: cover property ($rose(bus_join_out) && !ext_diagnostic_indicator_req_out);
  cov_clear: cover property (gcc_active_in && online_led_out);
endmodule // supervisor_checker
bind fieldbus_slave_status_supervisor supervisor_checker chk_i (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cfg_received_in(cfg_received_in),
  .dp_online_in(dp_online_in), .gcc_active_in(gcc_active_in),
  .wdog_timeout_in(wdog_timeout_in), .bus_join_out(bus_join_out),
  .ext_diagnostic_indicator_req_out(ext_diagnostic_indicator_req_out), .virtual_inputs_out(virtual_inputs_out),
  .online_led_out(online_led_out), .offline_led_out(offline_led_out),
  .fault_led_out(fault_led_out));
`default_nettype wire

// ---- tb/base_unit_model.sv ----
// Base unit stand-in: one configuration pulse a set time after reset
`timescale 1ns/100ps
`default_nettype none
module base_unit_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Delay in cycles, zero never sends, so the timeout path can be reached
  input wire logic [7:0] cfg_delay_in,
  // To the supervisor
  output logic cfg_received_out
);
  logic [7:0] cnt_reg;
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 8'h00;
      cfg_received_out <= 1'h0;
    end else begin
      if (cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h01;
      cfg_received_out <= (cfg_delay_in != 8'h00) && (cnt_reg == cfg_delay_in);
    end
  end
endmodule // base_unit_model
`default_nettype wire

// ---- tb/tb_fieldbus_slave_status_supervisor.sv ----
// Self-checking bench for the fieldbus slave status supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_fieldbus_slave_status_supervisor;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] tens, ones, ra = 4'h0;
  logic [7:0] cdel;
  logic [4:0] leds = 5'h0;
  logic dp_on, gcc, lenm, cfgm, initf, wdog, img_v = 1'h0, wr = 1'h0, rd = 1'h0, iq, dg, lv;
  logic [127:0] img = 128'h0, old;
  logic [31:0] wd = 32'h0, q;
  wire cfg, av, join_o, diagnostic_indicator, on_l, off_l, f_l, irq;
  wire [31:0] rdata;
  wire [6:0] sa;
  wire [127:0] vi;
  wire [7:0] sb;
  int errors = 0, samples_checked = 0, n, h, t, o;
  int unsigned seed = 81782;
  initial forever #50 clk = ~clk;
  base_unit_model bu (.core_clk_in(clk), .rst_n_in(rst_n), .cfg_delay_in(cdel),
    .cfg_received_out(cfg));
  // Short counts keep the timeout and flash codes within a brief run
  fieldbus_slave_status_supervisor #(.CFG_TIMEOUT_CYCLES(29'h32), .SLOW_HALF_CYCLES(23'h8),
    .MID_HALF_CYCLES(23'h4), .FAST_HALF_CYCLES(23'h2)) dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .tens_digit_selector_in(tens),
    .ones_digit_selector_in(ones), .cfg_received_in(cfg), .base_led_status_in(leds),
    .dp_online_in(dp_on), .gcc_active_in(gcc), .len_mismatch_in(lenm),
    .cfg_mismatch_in(cfgm), .dp_init_fail_in(initf), .wdog_timeout_in(wdog),
    .master_image_in(img), .master_image_valid_in(img_v), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .station_address_out(sa), .address_valid_out(av), .bus_join_out(join_o),
    .ext_diagnostic_indicator_req_out(diagnostic_indicator), .virtual_inputs_out(vi), .status_byte_out(sb),
    .online_led_out(on_l), .offline_led_out(off_l), .fault_led_out(f_l), .irq_out(irq));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [127:0] g, e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst(input logic [3:0] a, b, input logic [7:0] d);
    rst_n <= 1'h0;
    tens <= a;
    ones <= b;
    cdel <= d;
    {dp_on, gcc, wdog, initf, cfgm, lenm} <= 6'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  // Read data is picked up mid-cycle, where it stands for that one cycle only
  task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    @(negedge clk);
    q = rdata;
    iq = irq;
    @(posedge clk);
  endtask
  task automatic wj();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!join_o && n < 100);
    dg = diagnostic_indicator;
    @(posedge clk);
  endtask
  // Half period of a lamp from its last two changes, zero when it holds still
  task automatic hp(input logic s, output int hh);
    int e[$];
    logic p;
    repeat (3) @(posedge clk);
    @(negedge clk);
    p = s ? on_l : f_l;
    for (int j = 0; j < 40; j++) begin
      @(negedge clk);
      lv = s ? on_l : f_l;
      if (lv !== p) e.push_back(j);
      p = lv;
    end
    hh = e.size() > 1 ? e[$] - e[$-1] : 0;
    @(posedge clk);
  endtask
  initial begin
    rst(4'h3, 4'h6, 8'h00);
    wj();
    chk(dg, 1'h1);
    chk(n >= 50 && n <= 62, 1'h1);
    chk(sa, 7'h24);
    chk(av, 1'h1);
    chk({on_l, off_l}, 2'h1);
    tens <= 4'h7;
    rg(1'h0, 4'h4, 32'h0);
    chk(q[0], 1'h1);
    rg(1'h1, 4'h8, 32'h1);
    rg(1'h0, 4'h2, 32'h0);
    chk(q, 32'h0);
    chk(iq, 1'h1);
    rg(1'h1, 4'h4, 32'hf);
    rg(1'h0, 4'h0, 32'h0);
    chk(q[6:0], 7'h24);
    chk(iq, 1'h0);
    $display("test timeout join done");
    rst(4'ha, 4'h0, 8'h05);
    repeat (80) @(posedge clk);
    @(negedge clk);
    chk({join_o, av}, 2'h0);
    $display("test bad address done");
    t = rnd() % 10;
    o = rnd() % 10;
    rst(t[3:0], o[3:0], 8'h0a);
    wj();
    chk(dg, 1'h0);
    chk(n < 30, 1'h1);
    chk(sa, t * 10 + o);
    leds <= 5'(rnd());
    dp_on <= 1'h1;
    img <= {rnd(), rnd(), rnd(), rnd()};
    img_v <= 1'h1;
    @(posedge clk);
    img_v <= 1'h0;
    old = img;
    repeat (2) @(negedge clk);
    chk(vi, old);
    chk({on_l, off_l}, 2'h2);
    chk(sb, {2'h0, 1'h1, leds});
    @(posedge clk);
    gcc <= 1'h1;
    img <= ~old;
    img_v <= 1'h1;
    @(posedge clk);
    img_v <= 1'h0;
    hp(1'h1, h);
    chk(vi, {old[127:24], 24'h0});
    chk(h, 4);
    gcc <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      {wdog, initf, cfgm, lenm} <= 4'hf >> i;
      hp(1'h0, h);
      chk(h, (i == 0 || i == 4) ? 0 : 1 << i);
      if (h == 0) chk(lv, i == 0);
      rg(1'h0, 4'hc, 32'h0);
      chk(q[6:4], 4 - i);
    end
    $display("test joined operation done");
    end_sim();
  end
  // Tests need well under a thousand cycles; four thousand means a hang
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule // tb_fieldbus_slave_status_supervisor
`default_nettype wire
